// ==== pkg/spl_cfg.svh ====
// Purpose: timing, width and bit-position constants for the serial port phy
// Assumes: core clock of 100 MHz
// Notes:   cycle counts are derived from the nanosecond figures
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH

// ============================================================
// clock and pulse timing
`define SPL_CLK_MHZ        100
`define SPL_LONG_HALF_NS   150
`define SPL_SHORT_HALF_NS  50
`define SPL_THRESH_NS      100
`define SPL_RET_WIN_NS     500
`define SPL_CYC(ns)        ((((ns) * `SPL_CLK_MHZ) + 999) / 1000)

// ============================================================
// widths and depths
`define SPL_CNT_W          8
`define SPL_EV_W           2
`define SPL_FIFO_DEPTH     32

// ============================================================
// synchroniser bit positions and reset value
`define SPL_B_STRAP        0
`define SPL_B_CSB          1
`define SPL_B_SCK          2
`define SPL_B_SDI          3
`define SPL_B_RX           4
`define SPL_SYNC_W         8
`define SPL_SYNC_RST       8'h07

`endif

// ==== pkg/spl_pkg.sv ====
// Purpose: types shared by the serial port phy
// Assumes: nothing beyond the cfg header
// Notes:   event codes keep bit 1 low for chip-select events
package spl_pkg;

	// ============================================================
	// events and phases
	typedef enum logic [1:0] {
		SPL_EV_CS_RISE = 2'h0,
		SPL_EV_CS_FALL = 2'h1,
		SPL_EV_BIT0    = 2'h2,
		SPL_EV_BIT1    = 2'h3
	} spl_event_e;

	typedef enum logic [1:0] {
		SPL_PH_IDLE   = 2'h0,
		SPL_PH_FIRST  = 2'h1,
		SPL_PH_SECOND = 2'h3
	} spl_phase_e;

	function automatic logic spl_ev_long(input spl_event_e ev);
		return ~ev[1];
	endfunction

	function automatic logic spl_ev_pos(input spl_event_e ev);
		return ~(ev[1] ^ ev[0]);
	endfunction

	function automatic spl_event_e spl_ev_make(input logic is_long, input logic is_pos);
		spl_event_e ev;
		ev = spl_event_e'({~is_long, ~(is_pos ^ ~is_long)});
		return ev;
	endfunction

endpackage

// ==== design/spl_fifo.sv ====
// Purpose: event buffer between slave-port decoder and forwarding logic
// Assumes: DEPTH is a power of two
// Notes:   first-word-fall-through, no reset on the storage array
`timescale 1ns/100ps
`include "spl_cfg.svh"
module spl_fifo #(
	parameter int WIDTH = `SPL_EV_W,
	parameter int DEPTH = `SPL_FIFO_DEPTH
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	import spl_pkg::*;
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	// ============================================================
	// flags
	assign in_ready  = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// ============================================================
	// pointers
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (push) begin
			next_wr_ptr = wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

// ==== design/spl_phy.sv ====
// Purpose: physical layer of the monitor serial ports, 4-wire slave and pulse links
// Assumes: port 0 is primary, port 1 secondary; pulse inputs are comparator levels
// Notes:   all input pins pass three sync flops and a filter flop; the link is sampled, not clocked
`timescale 1ns/100ps
`include "spl_cfg.svh"
// Notes on behaviour
// [RL1] strap low selects 4-wire primary port
// [RL2] serial data out only pulls low
// [RL3] mode 3, data sampled on rising clock
// [RL4] host keeps data rate below 1 Mbps
// [RL5] secondary port is always a pulse link
// [RL6] 4-wire: primary slave, secondary master
// [RL7] host starts on primary of first device
// [RL8] pulse links: first active port becomes slave
// [RL9] addressable variant has primary port only
// [RL10] driver: positive, negative or both off
// [RL11] +1 is positive then negative half
// [RL12] -1 is negative then positive half
// [RL13] halves last 150 ns long, 50 ns short
// [RL14] master encodes chip-select and clock events
// [RL15] slave returns short -1 only; none means 1
// [RL16] receiver times first half against threshold
// [RL17] slave rebuilds chip-select, data, then clock
module spl_phy #(
	parameter bit CHAINED    = 1'b1,
	parameter int FIFO_DEPTH = `SPL_FIFO_DEPTH,
	parameter int CW         = `SPL_CNT_W
) (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       port_mode_strap,
	input  wire logic       spi_csb_n,
	input  wire logic       spi_sck,
	input  wire logic       spi_sdi,
	output logic            spi_sdo_out,
	output logic            spi_sdo_oe,
	input  wire logic [1:0] pulse_pos_pin_in,
	input  wire logic [1:0] pulse_neg_pin_in,
	output logic      [1:0] pulse_pos_pin_out,
	output logic      [1:0] pulse_pos_pin_oe,
	output logic      [1:0] pulse_neg_pin_out,
	output logic      [1:0] pulse_neg_pin_oe,
	input  wire logic       core_read_mode,
	input  wire logic       core_sdo,
	output logic            core_csb_n,
	output logic            core_sck_pulse,
	output logic            core_sdi,
	output spl_pkg::spl_event_e core_event,
	output logic            return_valid,
	output logic            return_bit,
	output logic            slave_is_secondary,
	output logic            event_lost
);
	import spl_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	localparam logic [CW-1:0] LONG_CYC  = CW'(`SPL_CYC(`SPL_LONG_HALF_NS));
	localparam logic [CW-1:0] SHORT_CYC = CW'(`SPL_CYC(`SPL_SHORT_HALF_NS));
	localparam logic [CW-1:0] THRESH    = CW'(`SPL_CYC(`SPL_THRESH_NS));
	localparam logic [CW-1:0] RET_WIN   = CW'(`SPL_CYC(`SPL_RET_WIN_NS));
	localparam logic [`SPL_SYNC_W-1:0] SYNC_RST = `SPL_SYNC_RST;

	// ============================================================
	// input synchronisers
	logic [`SPL_SYNC_W-1:0] raw, sy1, sy2, sy3, filt, filt_q, agree;
	logic [`SPL_SYNC_W-1:0] next_filt;
	logic                   mode_4w;

	assign raw = {pulse_neg_pin_in[1], pulse_pos_pin_in[1], pulse_neg_pin_in[0],
		pulse_pos_pin_in[0], spi_sdi, spi_sck, spi_csb_n, port_mode_strap};
	assign agree = ~(sy2 ^ sy3);

	// a bit moves only once the second and third stages agree
	always_comb begin
		next_filt = (filt & ~agree) | (sy3 & agree);
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sy1    <= SYNC_RST;
			sy2    <= SYNC_RST;
			sy3    <= SYNC_RST;
			filt   <= SYNC_RST;
			filt_q <= SYNC_RST;
		end else begin
			sy1    <= raw;
			sy2    <= sy1;
			sy3    <= sy2;
			filt   <= next_filt;
			filt_q <= filt;
		end
	end

	// [RL1] strap selects mode
	assign mode_4w = ~filt[`SPL_B_STRAP];

	// ============================================================
	// 4-wire event detect
	logic csb_fall, csb_rise, sck_rise;
	assign csb_fall = mode_4w & filt_q[`SPL_B_CSB] & ~filt[`SPL_B_CSB];
	assign csb_rise = mode_4w & ~filt_q[`SPL_B_CSB] & filt[`SPL_B_CSB];
	// [RL3] sample on rise
	assign sck_rise = mode_4w & ~filt[`SPL_B_CSB] & ~filt_q[`SPL_B_SCK] & filt[`SPL_B_SCK];

	// ============================================================
	// pulse receivers and transmitters, one per port
	spl_phase_e    rx_ph [2];
	spl_phase_e    next_rx_ph [2];
	spl_phase_e    tx_ph [2];
	spl_phase_e    next_tx_ph [2];
	logic [CW-1:0] rx_cnt [2];
	logic [CW-1:0] next_rx_cnt [2];
	logic [CW-1:0] tx_cnt [2];
	logic [CW-1:0] next_tx_cnt [2];
	logic [CW-1:0] tx_half [2];
	logic [CW-1:0] next_tx_half [2];
	logic [1:0]    rx_fpos, rx_long, rx_valid, next_rx_fpos, next_rx_long, next_rx_valid;
	logic [1:0]    tx_fpos, next_tx_fpos, tx_go, tx_go_long, tx_go_pos;

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			logic pos_lv, neg_lv, same_lv, opp_lv, drive_pos, active;
			assign pos_lv  = filt[`SPL_B_RX + 2*p] & ~filt[`SPL_B_RX + 2*p + 1];
			assign neg_lv  = filt[`SPL_B_RX + 2*p + 1] & ~filt[`SPL_B_RX + 2*p];
			assign same_lv = rx_fpos[p] ? pos_lv : neg_lv;
			assign opp_lv  = rx_fpos[p] ? neg_lv : pos_lv;

			always_comb begin
				next_rx_ph[p]    = rx_ph[p];
				next_rx_cnt[p]   = rx_cnt[p];
				next_rx_fpos[p]  = rx_fpos[p];
				next_rx_long[p]  = rx_long[p];
				next_rx_valid[p] = 1'b0;
				// [RL5] [RL9] port enables
				if (tx_ph[p] != SPL_PH_IDLE || (p == 1 && !CHAINED) || (p == 0 && mode_4w)) begin
					next_rx_ph[p] = SPL_PH_IDLE;
				end else begin
					case (rx_ph[p])
						SPL_PH_IDLE: begin
							if (pos_lv || neg_lv) begin
								next_rx_ph[p]   = SPL_PH_FIRST;
								next_rx_cnt[p]  = CW'(1);
								next_rx_fpos[p] = pos_lv;
							end
						end
						SPL_PH_FIRST: begin
							if (same_lv) begin
								if (rx_cnt[p] != '1) begin
									next_rx_cnt[p] = rx_cnt[p] + 1'b1;
								end
							end else if (opp_lv) begin
								next_rx_ph[p] = SPL_PH_SECOND;
								// [RL16] long or short
								next_rx_long[p] = rx_cnt[p] >= THRESH;
							end else begin
								next_rx_ph[p] = SPL_PH_IDLE;
							end
						end
						SPL_PH_SECOND: begin
							if (!opp_lv) begin
								next_rx_ph[p]    = SPL_PH_IDLE;
								next_rx_valid[p] = 1'b1;
							end
						end
						default: begin
							next_rx_ph[p] = SPL_PH_IDLE;
						end
					endcase
				end
			end

			always_comb begin
				next_tx_ph[p]   = tx_ph[p];
				next_tx_cnt[p]  = tx_cnt[p];
				next_tx_half[p] = tx_half[p];
				next_tx_fpos[p] = tx_fpos[p];
				case (tx_ph[p])
					SPL_PH_IDLE: begin
						if (tx_go[p]) begin
							next_tx_ph[p] = SPL_PH_FIRST;
							// [RL13] half width
							next_tx_half[p] = tx_go_long[p] ? LONG_CYC : SHORT_CYC;
							next_tx_cnt[p]  = (tx_go_long[p] ? LONG_CYC : SHORT_CYC) - 1'b1;
							next_tx_fpos[p] = tx_go_pos[p];
						end
					end
					SPL_PH_FIRST: begin
						if (tx_cnt[p] == '0) begin
							next_tx_ph[p]  = SPL_PH_SECOND;
							next_tx_cnt[p] = tx_half[p] - 1'b1;
						end else begin
							next_tx_cnt[p] = tx_cnt[p] - 1'b1;
						end
					end
					SPL_PH_SECOND: begin
						if (tx_cnt[p] == '0) begin
							next_tx_ph[p] = SPL_PH_IDLE;
						end else begin
							next_tx_cnt[p] = tx_cnt[p] - 1'b1;
						end
					end
					default: begin
						next_tx_ph[p] = SPL_PH_IDLE;
					end
				endcase
			end

			always_ff @(posedge clock) begin
				if (!reset_n) begin
					rx_ph[p]    <= SPL_PH_IDLE;
					rx_cnt[p]   <= '0;
					rx_fpos[p]  <= 1'b0;
					rx_long[p]  <= 1'b0;
					rx_valid[p] <= 1'b0;
					tx_ph[p]    <= SPL_PH_IDLE;
					tx_cnt[p]   <= '0;
					tx_half[p]  <= '0;
					tx_fpos[p]  <= 1'b0;
				end else begin
					rx_ph[p]    <= next_rx_ph[p];
					rx_cnt[p]   <= next_rx_cnt[p];
					rx_fpos[p]  <= next_rx_fpos[p];
					rx_long[p]  <= next_rx_long[p];
					rx_valid[p] <= next_rx_valid[p];
					tx_ph[p]    <= next_tx_ph[p];
					tx_cnt[p]   <= next_tx_cnt[p];
					tx_half[p]  <= next_tx_half[p];
					tx_fpos[p]  <= next_tx_fpos[p];
				end
			end

			// [RL11] [RL12] second half inverts
			assign drive_pos = (tx_ph[p] == SPL_PH_FIRST) ? tx_fpos[p] : ~tx_fpos[p];
			assign active    = tx_ph[p] != SPL_PH_IDLE;
			// [RL10] three drive states
			assign pulse_pos_pin_out[p] = active & drive_pos;
			assign pulse_neg_pin_out[p] = active & ~drive_pos;
			assign pulse_pos_pin_oe[p]  = active;
			assign pulse_neg_pin_oe[p]  = active;

			logic [CW-1:0] first_run;
			always_ff @(posedge clock) begin
				if (!reset_n || tx_ph[p] != SPL_PH_FIRST) begin
					first_run <= '0;
				end else begin
					first_run <= first_run + 1'b1;
				end
			end
			AST_THREE_STATES: assert property (pulse_pos_pin_oe[p] == pulse_neg_pin_oe[p] && // [RL10]
				(!pulse_pos_pin_oe[p] || pulse_pos_pin_out[p] != pulse_neg_pin_out[p]))
				else $error("pulse driver in an illegal state");
			AST_HALF_WIDTH: assert property (tx_ph[p] == SPL_PH_FIRST ##1 tx_ph[p] == SPL_PH_SECOND // [RL13]
				|-> (first_run == LONG_CYC || first_run == SHORT_CYC))
				else $error("first half-pulse has the wrong width");
			AST_PAIR_FLIP: assert property (tx_ph[p] == SPL_PH_FIRST ##1 tx_ph[p] == SPL_PH_SECOND // [RL11] [RL12]
				|-> pulse_pos_pin_out[p] != $past(pulse_pos_pin_out[p]))
				else $error("second half-pulse did not invert");
		end
	endgenerate

	// ============================================================
	// port roles
	logic slave, busy, next_slave, next_busy, master;

	always_comb begin
		next_slave = slave;
		next_busy  = busy;
		if (mode_4w || !CHAINED) begin
			// [RL6] [RL9] fixed roles
			next_slave = 1'b0;
			next_busy  = 1'b0;
		end else if (!busy) begin
			// [RL8] first traffic wins
			if (rx_valid[0]) begin
				next_slave = 1'b0;
				next_busy  = 1'b1;
			end else if (rx_valid[1]) begin
				next_slave = 1'b1;
				next_busy  = 1'b1;
			end
		end else if (rx_valid[slave] && rx_long[slave] && rx_fpos[slave]) begin
			next_busy = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			slave <= 1'b0;
			busy  <= 1'b0;
		end else begin
			slave <= next_slave;
			busy  <= next_busy;
		end
	end

	assign master             = ~next_slave;
	assign slave_is_secondary = slave;

	// ============================================================
	// event buffer and forwarding
	spl_event_e ev_data, fifo_ev;
	logic       ev_valid, fifo_in_ready, fifo_valid, fifo_ready, pop, ret_go;
	logic [`SPL_EV_W-1:0] fifo_out;
	logic [CW-1:0] win_cnt, next_win_cnt;
	logic win_bit, next_win_bit, next_return_valid, next_return_bit, ret_seen;

	always_comb begin
		ev_valid = 1'b0;
		ev_data  = SPL_EV_CS_RISE;
		if (mode_4w) begin
			ev_valid = csb_fall | csb_rise | sck_rise;
			if (csb_fall) begin
				ev_data = SPL_EV_CS_FALL;
			end else if (sck_rise) begin
				ev_data = filt[`SPL_B_SDI] ? SPL_EV_BIT1 : SPL_EV_BIT0;
			end
		end else if (rx_valid[next_slave]) begin
			ev_valid = 1'b1;
			ev_data  = spl_ev_make(rx_long[next_slave], rx_fpos[next_slave]);
		end
	end

	spl_fifo #(
		.WIDTH (`SPL_EV_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.reset_n   (reset_n),
		.in_valid  (ev_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (ev_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_out)
	);

	// the master waits for its return window so a late reply is not lost
	assign fifo_ev    = spl_event_e'(fifo_out);
	assign fifo_ready = !CHAINED || (tx_ph[master] == SPL_PH_IDLE && win_cnt == '0);
	assign pop        = fifo_valid & fifo_ready;
	// [RL15] reply only zeros
	assign ret_go = !mode_4w && busy && rx_valid[next_slave] && !rx_long[next_slave] &&
		core_read_mode && !core_sdo;

	always_comb begin
		tx_go      = 2'h0;
		tx_go_long = 2'h0;
		tx_go_pos  = 2'h0;
		// [RL14] forward events
		if (pop && CHAINED) begin
			tx_go[master]      = 1'b1;
			tx_go_long[master] = spl_ev_long(fifo_ev);
			tx_go_pos[master]  = spl_ev_pos(fifo_ev);
		end
		if (ret_go) begin
			tx_go[next_slave] = 1'b1;
		end
	end

	// ============================================================
	// return window and core side
	logic sck_pend, next_sck_pend, next_core_csb_n, next_core_sdi, next_core_sck_pulse;
	logic next_event_lost, next_sdo_oe;
	spl_event_e next_core_event;

	// [RL15] silence reads as 1
	assign ret_seen = rx_valid[master] && !rx_long[master] && !rx_fpos[master];

	always_comb begin
		next_win_cnt      = win_cnt;
		next_win_bit      = win_bit;
		next_return_valid = 1'b0;
		next_return_bit   = return_bit;
		if (pop && CHAINED && !spl_ev_long(fifo_ev)) begin
			next_win_cnt = RET_WIN;
			next_win_bit = 1'b1;
		end else if (win_cnt != '0) begin
			next_win_cnt = win_cnt - 1'b1;
			next_win_bit = win_bit & ~ret_seen;
			if (win_cnt == CW'(1)) begin
				next_return_valid = 1'b1;
				next_return_bit   = win_bit & ~ret_seen;
			end
		end
	end

	always_comb begin
		next_core_csb_n     = core_csb_n;
		next_core_sdi       = core_sdi;
		next_core_event     = core_event;
		next_core_sck_pulse = sck_pend;
		next_sck_pend       = 1'b0;
		// set wins: a lost event stays flagged until reset
		next_event_lost = event_lost | (ev_valid & ~fifo_in_ready);
		// [RL2] pull low only
		next_sdo_oe = mode_4w & ~filt[`SPL_B_CSB] & core_read_mode & ~core_sdo;
		// [RL17] rebuild core signals
		if (pop) begin
			next_core_event = fifo_ev;
			if (spl_ev_long(fifo_ev)) begin
				next_core_csb_n = spl_ev_pos(fifo_ev);
			end else begin
				next_core_sdi = spl_ev_pos(fifo_ev);
				next_sck_pend = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			win_cnt        <= '0;
			win_bit        <= 1'b1;
			return_valid   <= 1'b0;
			return_bit     <= 1'b1;
			core_csb_n     <= 1'b1;
			core_sdi       <= 1'b0;
			core_event     <= SPL_EV_CS_RISE;
			core_sck_pulse <= 1'b0;
			sck_pend       <= 1'b0;
			event_lost     <= 1'b0;
			spi_sdo_oe     <= 1'b0;
		end else begin
			win_cnt        <= next_win_cnt;
			win_bit        <= next_win_bit;
			return_valid   <= next_return_valid;
			return_bit     <= next_return_bit;
			core_csb_n     <= next_core_csb_n;
			core_sdi       <= next_core_sdi;
			core_event     <= next_core_event;
			core_sck_pulse <= next_core_sck_pulse;
			sck_pend       <= next_sck_pend;
			event_lost     <= next_event_lost;
			spi_sdo_oe     <= next_sdo_oe;
		end
	end

	assign spi_sdo_out = 1'b0;

	// ============================================================
	// checks
	AST_PRI_QUIET_4W: assert property (mode_4w && $past(mode_4w, 2) |-> !pulse_pos_pin_oe[0]) // [RL1]
		else $error("primary pulse driver active in 4-wire mode");
	AST_SDO_ONLY_LOW: assert property (spi_sdo_oe |-> !spi_sdo_out && $past(mode_4w) && // [RL2]
		!$past(filt[`SPL_B_CSB])) else $error("serial data out driven outside a 4-wire frame");
	AST_BIT_ON_RISE: assert property (mode_4w && ev_valid && !spl_ev_long(ev_data) // [RL3]
		|-> $rose(filt[`SPL_B_SCK])) else $error("bit taken without a rising clock");
	AST_ROLE_4W: assert property (mode_4w |=> !slave_is_secondary) // [RL6]
		else $error("secondary port became slave in 4-wire mode");
	AST_ROLE_HOLD: assert property (busy |=> slave_is_secondary == $past(slave_is_secondary)) // [RL8]
		else $error("slave port changed during a transaction");
	AST_NO_SECONDARY: assert property (!CHAINED |-> !pulse_pos_pin_oe[1]) // [RL9]
		else $error("secondary port driven on the addressable variant");
	AST_MASTER_ENC: assert property (pop && CHAINED |=> tx_ph[$past(master)] == SPL_PH_FIRST && // [RL14]
		tx_fpos[$past(master)] == spl_ev_pos($past(fifo_ev))) else $error("wrong master pulse");
	AST_SLAVE_SHORT_NEG: assert property (ret_go |=> tx_ph[slave] == SPL_PH_FIRST && // [RL15]
		!tx_fpos[slave] && tx_half[slave] == SHORT_CYC) else $error("slave reply not short -1");
	AST_SCK_AFTER_DATA: assert property (pop && !spl_ev_long(fifo_ev) |=> !core_sck_pulse // [RL17]
		##1 core_sck_pulse && core_sdi == spl_ev_pos($past(fifo_ev, 2)))
		else $error("internal clock not pulsed after data");
	COV_4W_FRAME: cover property (csb_fall ##[1:200] sck_rise);
	COV_SECONDARY_SLAVE: cover property (busy && slave_is_secondary);
	COV_RETURN_ZERO: cover property (return_valid && !return_bit);
	COV_LONG_TX: cover property (tx_ph[1] == SPL_PH_FIRST && tx_half[1] == LONG_CYC);
endmodule

// ==== tb/spl_far_end.sv ====
// Purpose: far-end pulse link partner for one port of the phy
// Assumes: comparator levels are 0/0 while nobody drives
// Notes:   counts half-pulse lengths of what the phy sends
`timescale 1ns/100ps
`include "spl_cfg.svh"
module spl_far_end (
	input  wire logic clock,
	input  wire logic pos_out,
	input  wire logic pos_oe,
	input  wire logic neg_out,
	input  wire logic neg_oe,
	output logic      pos_in = 1'b0,
	output logic      neg_in = 1'b0
);
	logic lp;
	logic ln;
	logic fp         = 1'b0;
	logic first_pos  = 1'b0;
	logic reply_zero = 1'b0;
	logic reply_req  = 1'b0;
	int   ph = 0, c1 = 0, c2 = 0, len1 = 0, len2 = 0, sym_count = 0, bad = 0;
	assign lp = pos_oe & pos_out & ~neg_out;
	assign ln = neg_oe & neg_out & ~pos_out;
	// ============================================================
	// sender
	// symmetric pulse pair
	task automatic send(input logic is_long, input logic is_pos);
		int n;
		n = is_long ? `SPL_CYC(`SPL_LONG_HALF_NS) : `SPL_CYC(`SPL_SHORT_HALF_NS);
		@(posedge clock);
		pos_in <= is_pos;
		neg_in <= ~is_pos;
		repeat (n) @(posedge clock);
		pos_in <= ~is_pos;
		neg_in <= is_pos;
		repeat (n) @(posedge clock);
		pos_in <= 1'b0;
		neg_in <= 1'b0;
	endtask
	// ============================================================
	// monitor of the phy's drive
	always @(posedge clock) begin
		reply_req <= 1'b0;
		if (pos_oe != neg_oe || (pos_oe && pos_out == neg_out))
			bad <= bad + 1;
		if (lp || ln) begin
			if (ph == 0) begin
				ph <= 1;
				fp <= lp;
				c1 <= 1;
			end else if (ph == 1 && lp == fp)
				c1 <= c1 + 1;
			else if (ph == 1) begin
				ph <= 2;
				c2 <= 1;
			end else
				c2 <= c2 + 1;
		end else if (ph != 0) begin
			ph        <= 0;
			len1      <= c1;
			len2      <= c2;
			first_pos <= fp;
			sym_count <= sym_count + 1;
			// reply short -1 for a 0
			reply_req <= reply_zero && c1 < `SPL_CYC(`SPL_THRESH_NS);
		end
	end
	initial forever begin
		@(negedge clock);
		if (reply_req)
			send(1'b0, 1'b0);
	end
endmodule

// ==== tb/spl_phy_tb.sv ====
// Purpose: self-checking bench of the serial port phy
// Assumes: one far-end partner per port
// Notes:   strap changes only under reset
`timescale 1ns/100ps
`include "spl_cfg.svh"
module spl_phy_tb;
	localparam int LH = `SPL_CYC(`SPL_LONG_HALF_NS);
	localparam int SH = `SPL_CYC(`SPL_SHORT_HALF_NS);
	logic clock = 1'b0, reset_n = 1'b0, port_mode_strap = 1'b1, spi_csb_n = 1'b1;
	logic spi_sck = 1'b1, spi_sdi = 1'b0, core_read_mode = 1'b0, core_sdo = 1'b1;
	logic spi_sdo_out, spi_sdo_oe, core_csb_n, core_sdi, core_sck_pulse;
	logic return_valid, return_bit, slave_is_secondary, event_lost;
	spl_pkg::spl_event_e core_event;
	wire logic [1:0] pin_p, pin_n;
	logic [1:0] out_p, oe_p, out_n, oe_n;
	int fail_count = 0, check_count = 0, cyc = 0, sck_count = 0;
	int base[2] = '{0, 0};
	spl_phy dut (.clock, .reset_n, .port_mode_strap, .spi_csb_n, .spi_sck, .spi_sdi,
		.spi_sdo_out, .spi_sdo_oe, .pulse_pos_pin_in(pin_p), .pulse_neg_pin_in(pin_n),
		.pulse_pos_pin_out(out_p), .pulse_pos_pin_oe(oe_p), .pulse_neg_pin_out(out_n),
		.pulse_neg_pin_oe(oe_n), .core_read_mode, .core_sdo, .core_csb_n,
		.core_sck_pulse, .core_sdi, .core_event, .return_valid, .return_bit,
		.slave_is_secondary, .event_lost);
	spl_far_end p0 (.clock, .pos_out(out_p[0]), .pos_oe(oe_p[0]), .neg_out(out_n[0]),
		.neg_oe(oe_n[0]), .pos_in(pin_p[0]), .neg_in(pin_n[0]));
	spl_far_end p1 (.clock, .pos_out(out_p[1]), .pos_oe(oe_p[1]), .neg_out(out_n[1]),
		.neg_oe(oe_n[1]), .pos_in(pin_p[1]), .neg_in(pin_n[1]));
	initial forever #5 clock = ~clock;
	// ============================================================
	// reporting
	task automatic end_of_test;
		$display("mismatches %0d of %0d checks", fail_count, check_count);
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		sck_count <= sck_count + int'(core_sck_pulse === 1'b1);
		if (cyc == 20000) begin
			fail_count++;
			$display("BAD %0t: run too long", $time);
			end_of_test;
		end
	end
	task automatic chk(input logic got, input logic exp);
		#1;
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t: got %b, wanted %b", $time, got, exp);
		end
	endtask
	task automatic expect_sym(input int port, input logic pos, input int half);
		int i;
		int n;
		i = 0;
		n = port ? p1.sym_count : p0.sym_count;
		while (n == base[port] && i < 500) begin
			@(posedge clock);
			#1;
			n = port ? p1.sym_count : p0.sym_count;
			i++;
		end
		base[port] = n;
		check_count++;
		if (i == 500 || (port ? p1.first_pos : p0.first_pos) !== pos ||
			(port ? p1.len1 : p0.len1) != half || (port ? p1.len2 : p0.len2) != half) begin
			fail_count++;
			$display("BAD %0t: wrong symbol on port %0d", $time, port);
		end
	endtask
	task automatic wait_ret(input logic exp);
		int i;
		i = 0;
		while (return_valid !== 1'b1 && i < 300) begin
			@(posedge clock);
			#1;
			i++;
		end
		chk(return_valid, 1'b1);
		chk(return_bit, exp);
	endtask
	// ============================================================
	// stimulus
	task automatic do_reset(input logic strap);
		@(posedge clock);
		reset_n         <= 1'b0;
		port_mode_strap <= strap;
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		repeat (8) @(posedge clock);
		base[0] = p0.sym_count;
		base[1] = p1.sym_count;
	endtask
	task automatic spi_bit(input logic b);
		@(posedge clock);
		spi_sck <= 1'b0;
		spi_sdi <= b;
		repeat (50) @(posedge clock);
		spi_sck <= 1'b1;
	endtask
	task automatic test_four_wire;
		do_reset(1'b0);
		core_read_mode <= 1'b1;
		core_sdo       <= 1'b0;
		@(posedge clock);
		spi_csb_n <= 1'b0;
		expect_sym(1, 1'b0, LH);
		chk(core_csb_n, 1'b0);
		chk(spi_sdo_oe, 1'b1);
		chk(spi_sdo_out, 1'b0);
		p1.reply_zero = 1'b1;
		spi_bit(1'b1);
		expect_sym(1, 1'b1, SH);
		wait_ret(1'b0);
		p1.reply_zero = 1'b0;
		spi_bit(1'b0);
		expect_sym(1, 1'b0, SH);
		wait_ret(1'b1);
		@(posedge clock);
		core_sdo <= 1'b1;
		repeat (5) @(posedge clock);
		chk(spi_sdo_oe, 1'b0);
		@(posedge clock);
		spi_csb_n <= 1'b1;
		expect_sym(1, 1'b1, LH);
		chk(p0.sym_count == 0, 1'b1);
		chk(sck_count == 2, 1'b1);
	endtask
	task automatic test_pulse;
		do_reset(1'b1);
		core_read_mode <= 1'b1;
		core_sdo       <= 1'b0;
		p1.send(1'b1, 1'b0);
		expect_sym(0, 1'b0, LH);
		chk(slave_is_secondary, 1'b1);
		chk(core_csb_n, 1'b0);
		p1.send(1'b0, 1'b1);
		expect_sym(1, 1'b0, SH);
		expect_sym(0, 1'b1, SH);
		chk(core_sdi, 1'b1);
		chk(core_event == spl_pkg::SPL_EV_BIT1, 1'b1);
		p1.send(1'b1, 1'b1);
		expect_sym(0, 1'b1, LH);
		chk(core_csb_n, 1'b1);
		p0.send(1'b1, 1'b0);
		expect_sym(1, 1'b0, LH);
		chk(slave_is_secondary, 1'b0);
		p0.send(1'b0, 1'b0);
		expect_sym(0, 1'b0, SH);
		expect_sym(1, 1'b0, SH);
		chk(core_sdi, 1'b0);
		p0.send(1'b1, 1'b1);
		expect_sym(1, 1'b1, LH);
		chk(core_event == spl_pkg::SPL_EV_CS_RISE, 1'b1);
		chk(sck_count == 4, 1'b1);
	endtask
	task automatic test_overflow;
		do_reset(1'b0);
		core_read_mode <= 1'b0;
		@(posedge clock);
		spi_csb_n <= 1'b0;
		chk(event_lost, 1'b0);
		// clocked far above the legal rate so the buffer must refuse
		repeat (45) begin
			repeat (4) @(posedge clock);
			spi_sck <= 1'b0;
			repeat (4) @(posedge clock);
			spi_sck <= 1'b1;
		end
		repeat (10) @(posedge clock);
		chk(event_lost, 1'b1);
	endtask
	initial begin
		test_four_wire;
		test_pulse;
		test_overflow;
		chk(p0.bad == 0 && p1.bad == 0, 1'b1);
		end_of_test;
	end
endmodule
